// ==== rtl/tcr_map.svh ====
// register offsets, field positions, reset values and timing counts of the temperature result block
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define TCR_ADDR_W 8
`define TCR_OFF_RESULT 8'h00
`define TCR_OFF_CONFIG 8'h04
`define TCR_OFF_STATUS 8'h08
`define TCR_OFF_COUNT 8'h0C

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define TCR_RESULT_RESET 16'h0550
`define TCR_RES_9 2'h0
`define TCR_RES_10 2'h1
`define TCR_RES_11 2'h2
`define TCR_RES_12 2'h3
`define TCR_RES_RESET 2'h3
`define TCR_CFG_RES_LSB 0
`define TCR_CFG_RES_MSB 1
`define TCR_ST_BUSY 0
`define TCR_ST_DONE 1
`define TCR_ST_EXT 2
`define TCR_ST_RES_LSB 4
`define TCR_ST_RES_MSB 5
`define TCR_SIGN_LSB 11

// ------------------------------------------------------------
// link command codes
// ------------------------------------------------------------
`define TCR_CMD_CONVERT 8'h44

// ------------------------------------------------------------
// timing: longest 12-bit conversion time, clock rate
// ------------------------------------------------------------
`define TCR_CONV_MAX_MS 400
`define TCR_CLK_MHZ 100
`define TCR_CONV_CYCLES (`TCR_CONV_MAX_MS * 1000 * `TCR_CLK_MHZ)

`endif

// ==== rtl/tcr_pkg.sv ====
// types shared by the temperature result block
package tcr_pkg;

    // ------------------------------------------------------------
    // conversion state machine
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        TCR_IDLE = 1'b0,
        TCR_CONV = 1'b1
    } tcr_state_t;

    // register bus request from the master
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tcr_bus_req_t;

    // decoded command byte from the link
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } tcr_cmd_t;

    // whole state of the top module
    typedef struct packed {
        tcr_state_t state;
        logic [15:0] result;
        logic [1:0] res_cfg;
        logic [1:0] res_run;
        logic done_flag;
        logic [15:0] conv_count;
        logic [31:0] rdata;
        logic slot_valid;
        logic slot_bit;
        logic busy;
        logic start;
        logic ext_meta;
        logic ext_sync;
    } tcr_regs_t;

endpackage : tcr_pkg

// ==== rtl/tcr_timer.sv ====
// conversion timer: counts the conversion time for the selected resolution
`timescale 1ns/1ps
`include "tcr_map.svh"

module tcr_timer #(
    parameter int unsigned CONV_CYCLES = `TCR_CONV_CYCLES,
    parameter int unsigned CNT_W = 26
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [1:0] i_res,
    output logic o_done
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic run_reg;
    logic run_next;
    logic done_reg;
    logic done_next;

    // ------------------------------------------------------------
    // conversion length halves for each bit of resolution dropped
    // ------------------------------------------------------------
    // start and done flops eat two cycles, so they come off the budget
    // to keep command-to-result inside the limit
    function automatic logic [CNT_W-1:0] conv_len(input logic [1:0] res);
        logic [CNT_W-1:0] full;
        logic [CNT_W-1:0] span;
        full = CNT_W'(CONV_CYCLES);
        span = full >> (2'h3 - res);
        conv_len = CNT_W'(1);
        if (span > CNT_W'(2)) begin
            conv_len = span - CNT_W'(2);
        end
    endfunction : conv_len

    // count down; last count pulses done for one cycle
    always_comb begin
        count_next = count_reg;
        run_next = run_reg;
        done_next = 1'b0;
        if (i_start && !run_reg) begin
            count_next = conv_len(i_res);
            run_next = 1'b1;
        end else if (run_reg) begin
            if (count_reg == CNT_W'(1)) begin
                run_next = 1'b0;
                done_next = 1'b1;
            end
            count_next = count_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            count_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg <= run_next;
            done_reg <= done_next;
        end
    end

    assign o_done = done_reg;

endmodule : tcr_timer

// ==== rtl/tcr_quant.sv ====
// result formatter: sign extension and resolution truncation of a raw sample
`timescale 1ns/1ps
`include "tcr_map.svh"

module tcr_quant (
    input wire logic [15:0] i_raw,
    input wire logic [1:0] i_res,
    output logic [15:0] o_result
);

    logic [15:0] ext;
    logic [15:0] keep;

    // ------------------------------------------------------------
    // bits 15..11 all copy the sign; undefined low bits forced to zero
    // ------------------------------------------------------------
    always_comb begin
        ext = {{5{i_raw[`TCR_SIGN_LSB]}}, i_raw[10:0]};
        keep = 16'hFFFF;
        if (i_res == `TCR_RES_11) begin
            keep = 16'hFFFE;
        end else if (i_res == `TCR_RES_10) begin
            keep = 16'hFFFC;
        end else if (i_res == `TCR_RES_9) begin
            keep = 16'hFFF8;
        end
        o_result = ext & keep;
    end

endmodule : tcr_quant

// ==== rtl/tcr_top.sv ====
// temperature conversion control and result register
`timescale 1ns/1ps
`include "tcr_map.svh"

// Functional notes
// - resolution selectable 9..12 bits, steps 0.5 down to 0.0625 degrees
// - resolution is 12 bits after reset until software changes it
// - after reset the block idles and starts nothing by itself
// - convert command byte from the master starts one conversion
// - finished conversion writes the result register, then back to idle
// - with external supply, read slots answer 0 while busy, 1 when done
// - result is 16-bit two's complement, bits 15..11 carry the sign
// - sign bits read 0 for positive, 1 for negative temperature
// - low bits below the chosen resolution are undefined; the block forces them to zero
// - result register resets to the code for plus 85 degrees
// - a 12-bit conversion ends within 400 ms of its start
module tcr_top #(
    parameter int unsigned CONV_CYCLES = `TCR_CONV_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic i_read_slot,
    input wire logic i_external_supply_pin,
    input wire logic [15:0] i_sensor_raw,
    output logic [31:0] o_rdata,
    output logic o_slot_valid,
    output logic o_slot_bit,
    output logic o_busy
);

    // ------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------
    tcr_pkg::tcr_bus_req_t bus;
    tcr_pkg::tcr_cmd_t cmd;
    tcr_pkg::tcr_regs_t state_reg;
    tcr_pkg::tcr_regs_t state_next;
    logic conv_done;
    logic [15:0] new_result;

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign cmd = '{valid: i_cmd_valid, code: i_cmd_code};

    // ------------------------------------------------------------
    // conversion time and result formatting
    // ------------------------------------------------------------
    tcr_timer #(
        .CONV_CYCLES(CONV_CYCLES),
        .CNT_W(26)
    ) u_timer (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(state_reg.start),
        .i_res(state_reg.res_run),
        .o_done(conv_done)
    );

    // resolution taken at start, so a config write mid-conversion is harmless
    tcr_quant u_quant (
        .i_raw(i_sensor_raw),
        .i_res(state_reg.res_run),
        .o_result(new_result)
    );

    // ------------------------------------------------------------
    // register read mux, unmapped addresses read zero
    // ------------------------------------------------------------
    function automatic logic [31:0] read_word(input tcr_pkg::tcr_regs_t s, input logic [7:0] addr);
        read_word = 32'h0000_0000;
        if (addr == `TCR_OFF_RESULT) begin
            read_word[15:0] = s.result;
        end else if (addr == `TCR_OFF_CONFIG) begin
            read_word[`TCR_CFG_RES_MSB:`TCR_CFG_RES_LSB] = s.res_cfg;
        end else if (addr == `TCR_OFF_STATUS) begin
            read_word[`TCR_ST_BUSY] = (s.state == tcr_pkg::TCR_CONV);
            read_word[`TCR_ST_DONE] = s.done_flag;
            read_word[`TCR_ST_EXT] = s.ext_sync;
            read_word[`TCR_ST_RES_MSB:`TCR_ST_RES_LSB] = s.res_run;
        end else if (addr == `TCR_OFF_COUNT) begin
            read_word[15:0] = s.conv_count;
        end
    endfunction : read_word

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.start = 1'b0;
        state_next.slot_valid = 1'b0;
        state_next.rdata = 32'h0000_0000;

        // supply strap is a pin: two flops before anyone reads it
        state_next.ext_meta = i_external_supply_pin;
        state_next.ext_sync = state_reg.ext_meta;

        // software sets resolution; other registers ignore writes
        if (bus.wr && bus.addr == `TCR_OFF_CONFIG) begin
            state_next.res_cfg = bus.wdata[`TCR_CFG_RES_MSB:`TCR_CFG_RES_LSB];
        end

        // reading status clears the done flag
        if (bus.rd) begin
            state_next.rdata = read_word(state_reg, bus.addr);
            if (bus.addr == `TCR_OFF_STATUS) begin
                state_next.done_flag = 1'b0;
            end
        end

        case (state_reg.state)
            tcr_pkg::TCR_IDLE: begin
                // nothing starts without a command
                if (cmd.valid && cmd.code == `TCR_CMD_CONVERT) begin
                    state_next.state = tcr_pkg::TCR_CONV;
                    state_next.start = 1'b1;
                    state_next.res_run = state_reg.res_cfg;
                    state_next.busy = 1'b1;
                end
            end
            tcr_pkg::TCR_CONV: begin
                // further convert commands are ignored while busy
                if (conv_done) begin
                    state_next.result = new_result;
                    state_next.state = tcr_pkg::TCR_IDLE;
                    state_next.busy = 1'b0;
                    state_next.done_flag = 1'b1; // set wins over a same-cycle clear
                    state_next.conv_count = state_reg.conv_count + 16'h0001;
                end
            end
            default: begin
                state_next.state = tcr_pkg::TCR_IDLE;
            end
        endcase

        // read slot answer only when externally powered; parasite mode stays silent
        if (i_read_slot && state_reg.ext_sync) begin
            state_next.slot_valid = 1'b1;
            state_next.slot_bit = (state_reg.state == tcr_pkg::TCR_IDLE);
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_reg.state <= tcr_pkg::TCR_IDLE;
            state_reg.result <= `TCR_RESULT_RESET;
            state_reg.res_cfg <= `TCR_RES_RESET;
            state_reg.res_run <= `TCR_RES_RESET;
            state_reg.done_flag <= 1'b0;
            state_reg.conv_count <= 16'h0000;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.slot_valid <= 1'b0;
            state_reg.slot_bit <= 1'b1;
            state_reg.busy <= 1'b0;
            state_reg.start <= 1'b0;
            state_reg.ext_meta <= 1'b0;
            state_reg.ext_sync <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign o_rdata = state_reg.rdata;
    assign o_slot_valid = state_reg.slot_valid;
    assign o_slot_bit = state_reg.slot_bit;
    assign o_busy = state_reg.busy;

endmodule : tcr_top

// ==== dv/tcr_assertions.sv ====
// port checker of the temperature result block
`timescale 1ns/1ps
module tcr_checker #(
    parameter int unsigned CONV_CYCLES = 64
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic i_read_slot,
    input wire logic i_external_supply_pin,
    input wire logic [31:0] o_rdata,
    input wire logic o_slot_valid,
    input wire logic o_slot_bit,
    input wire logic o_busy
);
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    localparam int MAXW = CONV_CYCLES;
    logic ext_meta;
    logic ext_sync;
    logic start_cmd;
    // supply mirror with two flops, so slot answers line up with the block
    always_ff @(posedge i_core_clk) begin
        ext_meta <= i_sys_rst ? 1'b0 : i_external_supply_pin;
        ext_sync <= i_sys_rst ? 1'b0 : ext_meta;
    end
    assign start_cmd = i_cmd_valid && (i_cmd_code == 8'h44);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    property p_idle_stays; !o_busy && !start_cmd |=> !o_busy; endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("busy without start");
    property p_start; start_cmd && !o_busy |=> o_busy; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_conv_bound; $rose(o_busy) |-> ##[1:MAXW] !o_busy; endproperty
    a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");
    property p_status_busy; i_rd && i_addr == 8'h08 |=> o_rdata[0] == $past(o_busy); endproperty
    a_status_busy: assert property (p_status_busy) else $error("status busy wrong");
    property p_res_upper; i_rd && i_addr == 8'h00 |=> o_rdata[31:16] == 16'h0000; endproperty
    a_res_upper: assert property (p_res_upper) else $error("result upper bits set");
    property p_sign; i_rd && i_addr == 8'h00 |=> o_rdata[15:11] == 5'h00 || o_rdata[15:11] == 5'h1F; endproperty
    a_sign: assert property (p_sign) else $error("sign bits differ");
    property p_slot; i_read_slot && ext_sync |=> o_slot_valid && o_slot_bit == !$past(o_busy); endproperty
    a_slot: assert property (p_slot) else $error("slot answer wrong");
    property p_no_slot; !(i_read_slot && ext_sync) |=> !o_slot_valid; endproperty
    a_no_slot: assert property (p_no_slot) else $error("slot answer unasked");
endmodule : tcr_checker

bind tcr_top tcr_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.i_core_clk, .i_sys_rst, .i_addr, .i_rd,
    .i_cmd_valid, .i_cmd_code, .i_read_slot, .i_external_supply_pin, .o_rdata, .o_slot_valid, .o_slot_bit, .o_busy);

// ==== dv/tcr_master_model.sv ====
// bus master model: command bytes, read slots, supply level and sensor sample
`timescale 1ns/1ps
module tcr_master_model (
    input wire logic i_core_clk,
    input wire logic i_slot_valid,
    input wire logic i_slot_bit,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_code,
    output logic o_read_slot,
    output logic o_external_supply_pin,
    output logic [15:0] o_sensor_raw
);
    // ------------------------------------------------------------
    // master actions
    // ------------------------------------------------------------
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'hA5;
        o_read_slot = 1'b0;
        o_external_supply_pin = 1'b1;
        o_sensor_raw = 16'h0000;
    end
    // supply and sample change only between conversions
    task automatic set_env(input logic ext, input logic [15:0] raw);
        @(posedge i_core_clk);
        o_external_supply_pin <= ext;
        o_sensor_raw <= raw;
    endtask : set_env
    // code inverted after the byte so a stale value is never mistaken for one
    task automatic send_cmd(input logic [7:0] code);
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_code <= code;
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_code <= ~code;
    endtask : send_cmd
    // no slot on parasite power unless a test insists
    task automatic poll(input logic insist, output logic valid, output logic bit_v);
        valid = 1'b0;
        bit_v = 1'b0;
        if (o_external_supply_pin || insist) begin
            @(posedge i_core_clk);
            o_read_slot <= 1'b1;
            @(posedge i_core_clk);
            o_read_slot <= 1'b0;
            #1;
            valid = i_slot_valid;
            bit_v = i_slot_bit;
        end
    endtask : poll
endmodule : tcr_master_model

// ==== dv/test_temperature_conversion_result.sv ====
// self-checking bench of the temperature result block
`timescale 1ns/1ps
module test_temperature_conversion_result;
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    localparam int unsigned CONV = 64;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic cmd_valid, read_slot, ext_pin, slot_valid, slot_bit, busy, sv, sb;
    logic [7:0] cmd_code;
    logic [15:0] raw, prev;
    logic [31:0] rdata, rv;
    logic [15:0] raws [4] = '{16'h0191, 16'h0E6F, 16'h00A2, 16'h0F5E};
    int failures = 0;
    int cmp_count = 0;
    int n;
    always #5 i_core_clk = ~i_core_clk;
    tcr_top #(.CONV_CYCLES(CONV)) DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
        .i_read_slot(read_slot), .i_external_supply_pin(ext_pin), .i_sensor_raw(raw), .o_rdata(rdata),
        .o_slot_valid(slot_valid), .o_slot_bit(slot_bit), .o_busy(busy));
    tcr_master_model mdl (.i_core_clk(i_core_clk), .i_slot_valid(slot_valid), .i_slot_bit(slot_bit),
        .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code), .o_read_slot(read_slot),
        .o_external_supply_pin(ext_pin), .o_sensor_raw(raw));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : reg_wr
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    // bounded wait for the end of a conversion, counting edges
    task automatic wait_idle(inout int cnt);
        while (busy !== 1'b0) begin
            @(posedge i_core_clk);
            #1;
            cnt++;
            if (cnt > 1000) begin
                failures++;
                final_report();
            end
        end
    endtask : wait_idle
    function automatic logic [15:0] exp_res(input logic [15:0] r_raw, input int r);
        return {{5{r_raw[11]}}, r_raw[10:0]} & (16'hFFFF << (3 - r));
    endfunction : exp_res
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        reg_wr(8'h00, 32'hFFFF);
        reg_rd(8'h00, rv);
        chk("result", 32'h0550, rv);
        reg_rd(8'h04, rv);
        chk("config", 32'h3, rv);
        reg_rd(8'h10, rv);
        chk("unmapped", 32'h0, rv);
        mdl.send_cmd(8'h48);
        mdl.send_cmd(8'hBE);
        #1;
        chk("busy", 32'h0, {31'h0, busy});
        $display("test reset done");
        prev = 16'h0550;
        // every resolution, with a read, a repeated start and a slot mid-way
        for (int r = 0; r < 4; r++) begin
            mdl.set_env(1'b1, raws[r]);
            reg_wr(8'h04, r);
            mdl.send_cmd(8'h44);
            #1;
            reg_rd(8'h00, rv);
            chk("held", {16'h0, prev}, rv);
            mdl.send_cmd(8'h44);
            mdl.poll(1'b0, sv, sb);
            chk("slot busy", 32'h2, {30'h0, sv, sb});
            n = 6;
            wait_idle(n);
            chk("time", CONV >> (3 - r), n);
            mdl.poll(1'b0, sv, sb);
            chk("slot done", 32'h3, {30'h0, sv, sb});
            prev = exp_res(raws[r], r);
            reg_rd(8'h00, rv);
            chk("result", {16'h0, prev}, rv);
            reg_rd(8'h08, rv);
            chk("status", (r << 4) | 6, rv);
            reg_rd(8'h08, rv);
            chk("status", (r << 4) | 4, rv);
            reg_rd(8'h0C, rv);
            chk("count", r + 1, rv);
        end
        $display("test conversions done");
        mdl.set_env(1'b0, 16'h0);
        repeat (3) @(posedge i_core_clk);
        mdl.poll(1'b1, sv, sb);
        chk("parasite slot", 32'h0, {31'h0, sv});
        reg_rd(8'h08, rv);
        chk("parasite status", 32'h30, rv);
        $display("test parasite done");
        final_report();
    end
endmodule : test_temperature_conversion_result
